/* File: design/sram_pkg.sv */
package sram_pkg;

  localparam int ADDR_W = 20;
  localparam int DATA_W = 18;
  localparam int WORD_IDX_W = 2;
  localparam int MEM_ADDR_W = 22;
  localparam int BURST_W = 72;
  localparam int SEL_BURST_W = 8;
  localparam int LANE0_MSB = 8;
  localparam int LANE1_LSB = 9;
  localparam int STEP_W = 4;

  // Rise counts after the starting positive rise, which is step 0.
  localparam logic [STEP_W-1:0] STEP_START = 4'h0;
  localparam logic [STEP_W-1:0] STEP_ONE = 4'h1;
  localparam logic [STEP_W-1:0] WR_FIRST_STEP = 4'h2;
  localparam logic [STEP_W-1:0] WR_LAST_STEP = 4'h5;
  localparam logic [STEP_W-1:0] RD_FIRST_STEP = 4'h5;
  localparam logic [STEP_W-1:0] RD_LAST_STEP = 4'h8;
  localparam logic [WORD_IDX_W-1:0] LAST_WORD = 2'h3;

  localparam logic [DATA_W-1:0] DATA_RESET = 18'h00000;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 20'h00000;
  localparam logic [BURST_W-1:0] BURST_RESET = 72'h000000000000000000;
  localparam logic [1:0] BYTE_SEL_IDLE = 2'h3;

  typedef struct packed {
    logic active;
    logic [STEP_W-1:0] step;
    logic [ADDR_W-1:0] addr;
  } slot_t;

  localparam slot_t SLOT_RESET = '{1'b0, 4'h0, 20'h00000};

  typedef enum logic [1:0] {
    CLK_STOPPED = 2'b00,
    CLK_RESTART = 2'b01,
    CLK_RUNNING = 2'b10
  } clk_state_t;

  function automatic slot_t slot_start(input logic [ADDR_W-1:0] addr);
    slot_t r;
    r.active = 1'b1;
    r.step = STEP_START;
    r.addr = addr;
    return r;
  endfunction : slot_start

  // A slot stays active through its last step and frees on the next rise.
  function automatic slot_t slot_advance(input slot_t s, input logic [STEP_W-1:0] last);
    slot_t r;
    r = s;
    if (s.active) begin
      r.step = s.step + STEP_ONE;
      r.active = (s.step != last);
    end
    return r;
  endfunction : slot_advance

  function automatic logic in_window(input slot_t s, input logic [STEP_W-1:0] first,
                                     input logic [STEP_W-1:0] last);
    return s.active && (s.step >= first) && (s.step <= last);
  endfunction : in_window

  function automatic logic [WORD_IDX_W-1:0] word_index(input logic [STEP_W-1:0] step,
                                                       input logic [STEP_W-1:0] first);
    logic [STEP_W-1:0] diff;
    diff = step - first;
    return diff[WORD_IDX_W-1:0];
  endfunction : word_index

  function automatic logic [DATA_W-1:0] lane_merge(input logic [DATA_W-1:0] old_word,
                                                   input logic [DATA_W-1:0] new_word,
                                                   input logic [1:0] sel_n);
    logic [DATA_W-1:0] r;
    r = old_word;
    if (!sel_n[0]) begin
      r[LANE0_MSB:0] = new_word[LANE0_MSB:0];
    end
    if (!sel_n[1]) begin
      r[DATA_W-1:LANE1_LSB] = new_word[DATA_W-1:LANE1_LSB];
    end
    return r;
  endfunction : lane_merge

endpackage : sram_pkg

/* File: design/sram_link_if.sv */
`timescale 1ns/1ps
interface sram_link_if;
  logic k;
  logic k_n;
  logic read_port_select_n;
  logic write_port_select_n;
  logic [sram_pkg::ADDR_W-1:0] addr;
  logic [sram_pkg::DATA_W-1:0] d;
  logic [1:0] byte_write_select_n;
  logic [sram_pkg::DATA_W-1:0] q;
  logic q_oe;

  modport ctrl_mp (
    output k, k_n, read_port_select_n, write_port_select_n, addr, d, byte_write_select_n,
    input q, q_oe
  );

  modport dev_mp (
    input k, k_n, read_port_select_n, write_port_select_n, addr, d, byte_write_select_n,
    output q, q_oe
  );
endinterface : sram_link_if

/* File: design/sram_device.sv */
`timescale 1ns/1ps
module sram_device (
  input wire logic clk_in,
  input wire logic nrst_in,
  sram_link_if.dev_mp link,
  output logic rd_busy_out,
  output logic wr_busy_out,
  output logic rd_dropped_out,
  output logic wr_dropped_out
);

  logic k_prev_reg;
  logic kn_prev_reg;
  logic k_rise;
  logic kn_rise;
  logic any_rise;
  logic rd_last_reg;
  logic wr_last_reg;
  logic rd_go;
  logic wr_go;
  logic rd_sel_reg;
  logic wr_sel_reg;
  sram_pkg::slot_t rd_slot_reg [2];
  sram_pkg::slot_t wr_slot_reg [2];
  sram_pkg::slot_t rd_slot_next [2];
  sram_pkg::slot_t wr_slot_next [2];
  logic rd_hit;
  logic [sram_pkg::MEM_ADDR_W-1:0] rd_word_addr;
  logic wr_hit;
  logic [sram_pkg::MEM_ADDR_W-1:0] wr_word_addr;
  logic [sram_pkg::DATA_W-1:0] q_reg;
  logic q_oe_reg;
  logic [sram_pkg::DATA_W-1:0] mem [0:(2**sram_pkg::MEM_ADDR_W)-1];

  // A rise counts only while the partner clock is low, so parking both high does not look like one.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      k_prev_reg <= 1'b1;
      kn_prev_reg <= 1'b1;
    end else begin
      k_prev_reg <= link.k;
      kn_prev_reg <= link.k_n;
    end
  end

  assign k_rise = link.k & ~k_prev_reg & ~link.k_n;
  assign kn_rise = link.k_n & ~kn_prev_reg & ~link.k;
  assign any_rise = k_rise | kn_rise;

  // Selects are looked at only on positive rises; a select that started the last cycle is ignored.
  assign rd_go = k_rise & ~link.read_port_select_n & ~rd_last_reg;
  assign wr_go = k_rise & ~link.write_port_select_n & ~wr_last_reg & ~rd_go;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rd_last_reg <= 1'b0;
      wr_last_reg <= 1'b0;
    end else if (k_rise) begin
      rd_last_reg <= rd_go;
      wr_last_reg <= wr_go;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rd_dropped_out <= 1'b0;
      wr_dropped_out <= 1'b0;
    end else begin
      rd_dropped_out <= k_rise & ~link.read_port_select_n & rd_last_reg;
      wr_dropped_out <= k_rise & ~link.write_port_select_n & wr_last_reg;
    end
  end

  // Two slots per port, since a new burst may start while the previous one is still moving data.
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      if (rd_go && (rd_sel_reg == 1'(i))) begin
        rd_slot_next[i] = sram_pkg::slot_start(link.addr);
      end else begin
        rd_slot_next[i] = sram_pkg::slot_advance(rd_slot_reg[i], sram_pkg::RD_LAST_STEP);
      end
      if (wr_go && (wr_sel_reg == 1'(i))) begin
        wr_slot_next[i] = sram_pkg::slot_start(link.addr);
      end else begin
        wr_slot_next[i] = sram_pkg::slot_advance(wr_slot_reg[i], sram_pkg::WR_LAST_STEP);
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rd_sel_reg <= 1'b0;
      wr_sel_reg <= 1'b0;
      for (int i = 0; i < 2; i++) begin
        rd_slot_reg[i] <= sram_pkg::SLOT_RESET;
        wr_slot_reg[i] <= sram_pkg::SLOT_RESET;
      end
    end else if (any_rise) begin
      if (rd_go) begin
        rd_sel_reg <= ~rd_sel_reg;
      end
      if (wr_go) begin
        wr_sel_reg <= ~wr_sel_reg;
      end
      for (int i = 0; i < 2; i++) begin
        rd_slot_reg[i] <= rd_slot_next[i];
        wr_slot_reg[i] <= wr_slot_next[i];
      end
    end
  end

  // Windows never overlap within a port because starts of one kind are two cycles apart.
  always_comb begin
    rd_hit = 1'b0;
    rd_word_addr = {sram_pkg::ADDR_RESET, 2'h0};
    wr_hit = 1'b0;
    wr_word_addr = {sram_pkg::ADDR_RESET, 2'h0};
    for (int i = 0; i < 2; i++) begin
      if (sram_pkg::in_window(rd_slot_next[i], sram_pkg::RD_FIRST_STEP, sram_pkg::RD_LAST_STEP)) begin
        rd_hit = 1'b1;
        rd_word_addr = {rd_slot_next[i].addr,
                        sram_pkg::word_index(rd_slot_next[i].step, sram_pkg::RD_FIRST_STEP)};
      end
      if (sram_pkg::in_window(wr_slot_next[i], sram_pkg::WR_FIRST_STEP, sram_pkg::WR_LAST_STEP)) begin
        wr_hit = 1'b1;
        wr_word_addr = {wr_slot_next[i].addr,
                        sram_pkg::word_index(wr_slot_next[i].step, sram_pkg::WR_FIRST_STEP)};
      end
    end
  end

  // Each word is merged into the array as it arrives, so a later read sees it without a bypass path.
  always_ff @(posedge clk_in) begin
    if (any_rise && wr_hit) begin
      mem[wr_word_addr] <= sram_pkg::lane_merge(mem[wr_word_addr], link.d,
                                                link.byte_write_select_n);
    end
  end

  // Without rises nothing here moves, so the pins keep their last state while the clocks stand.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      q_reg <= sram_pkg::DATA_RESET;
      q_oe_reg <= 1'b0;
    end else if (any_rise) begin
      if (rd_hit) begin
        q_reg <= mem[rd_word_addr];
        q_oe_reg <= 1'b1;
      end else begin
        q_oe_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rd_busy_out <= 1'b0;
      wr_busy_out <= 1'b0;
    end else begin
      rd_busy_out <= rd_slot_reg[0].active | rd_slot_reg[1].active;
      wr_busy_out <= wr_slot_reg[0].active | wr_slot_reg[1].active;
    end
  end

  assign link.q = q_reg;
  assign link.q_oe = q_oe_reg;

endmodule : sram_device

/* File: design/sram_controller.sv */
`timescale 1ns/1ps
module sram_controller (
  input wire logic clk_in,
  input wire logic nrst_in,
  sram_link_if.ctrl_mp link,
  input wire logic clk_run_in,
  input wire logic rd_req_in,
  input wire logic [sram_pkg::ADDR_W-1:0] rd_addr_in,
  input wire logic wr_req_in,
  input wire logic [sram_pkg::ADDR_W-1:0] wr_addr_in,
  input wire logic [sram_pkg::BURST_W-1:0] wr_data_in,
  input wire logic [sram_pkg::SEL_BURST_W-1:0] wr_byte_sel_n_in,
  output logic rd_ack_out,
  output logic wr_ack_out,
  output logic [sram_pkg::BURST_W-1:0] rd_data_out,
  output logic rd_valid_out
);

  sram_pkg::clk_state_t clk_state_reg;
  logic phase_reg;
  logic rise_now;
  logic k_now;
  logic rd_issue;
  logic wr_issue;
  logic rd_last_reg;
  logic wr_last_reg;
  logic rd_sel_reg;
  logic wr_sel_reg;
  sram_pkg::slot_t rd_slot_reg [2];
  sram_pkg::slot_t wr_slot_reg [2];
  sram_pkg::slot_t rd_slot_next [2];
  sram_pkg::slot_t wr_slot_next [2];
  logic [sram_pkg::BURST_W-1:0] wr_buf_reg [2];
  logic [sram_pkg::SEL_BURST_W-1:0] wr_bsel_reg [2];
  logic rd_hit;
  logic [sram_pkg::WORD_IDX_W-1:0] rd_idx;
  logic wr_hit;
  logic [sram_pkg::DATA_W-1:0] wr_word;
  logic [1:0] wr_word_sel_n;
  logic k_reg;
  logic kn_reg;
  logic rd_port_n_reg;
  logic wr_port_n_reg;
  logic [sram_pkg::ADDR_W-1:0] addr_reg;
  logic [sram_pkg::DATA_W-1:0] d_reg;
  logic [1:0] bsel_n_reg;
  logic cap1_reg;
  logic cap2_reg;
  logic [sram_pkg::WORD_IDX_W-1:0] cap1_idx_reg;
  logic [sram_pkg::WORD_IDX_W-1:0] cap2_idx_reg;
  logic [sram_pkg::BURST_W-1:0] rd_buf_reg;

  assign rise_now = clk_run_in && (clk_state_reg == sram_pkg::CLK_RUNNING);
  assign k_now = rise_now & ~phase_reg;
  assign rd_issue = k_now & rd_req_in & ~rd_last_reg;
  assign wr_issue = k_now & wr_req_in & ~wr_last_reg & ~rd_issue;

  // A restart first drives the pattern of the phase before, so the next rise is a clean one.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      clk_state_reg <= sram_pkg::CLK_STOPPED;
      phase_reg <= 1'b0;
      k_reg <= 1'b1;
      kn_reg <= 1'b1;
    end else begin
      case (clk_state_reg)
        sram_pkg::CLK_STOPPED: begin
          if (clk_run_in) begin
            k_reg <= phase_reg;
            kn_reg <= ~phase_reg;
            clk_state_reg <= sram_pkg::CLK_RUNNING;
          end
        end
        sram_pkg::CLK_RUNNING: begin
          if (clk_run_in) begin
            k_reg <= ~phase_reg;
            kn_reg <= phase_reg;
            phase_reg <= ~phase_reg;
          end else begin
            k_reg <= 1'b1;
            kn_reg <= 1'b1;
            clk_state_reg <= sram_pkg::CLK_STOPPED;
          end
        end
        default: begin
          clk_state_reg <= sram_pkg::CLK_STOPPED;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rd_last_reg <= 1'b0;
      wr_last_reg <= 1'b0;
      rd_port_n_reg <= 1'b1;
      wr_port_n_reg <= 1'b1;
      addr_reg <= sram_pkg::ADDR_RESET;
      rd_ack_out <= 1'b0;
      wr_ack_out <= 1'b0;
    end else begin
      rd_port_n_reg <= ~rd_issue;
      wr_port_n_reg <= ~wr_issue;
      rd_ack_out <= rd_issue;
      wr_ack_out <= wr_issue;
      if (k_now) begin
        rd_last_reg <= rd_issue;
        wr_last_reg <= wr_issue;
      end
      if (rd_issue) begin
        addr_reg <= rd_addr_in;
      end else if (wr_issue) begin
        addr_reg <= wr_addr_in;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      if (rd_issue && (rd_sel_reg == 1'(i))) begin
        rd_slot_next[i] = sram_pkg::slot_start(rd_addr_in);
      end else begin
        rd_slot_next[i] = sram_pkg::slot_advance(rd_slot_reg[i], sram_pkg::RD_LAST_STEP);
      end
      if (wr_issue && (wr_sel_reg == 1'(i))) begin
        wr_slot_next[i] = sram_pkg::slot_start(wr_addr_in);
      end else begin
        wr_slot_next[i] = sram_pkg::slot_advance(wr_slot_reg[i], sram_pkg::WR_LAST_STEP);
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rd_sel_reg <= 1'b0;
      wr_sel_reg <= 1'b0;
      for (int i = 0; i < 2; i++) begin
        rd_slot_reg[i] <= sram_pkg::SLOT_RESET;
        wr_slot_reg[i] <= sram_pkg::SLOT_RESET;
        wr_buf_reg[i] <= sram_pkg::BURST_RESET;
        wr_bsel_reg[i] <= 8'hFF;
      end
    end else if (rise_now) begin
      if (rd_issue) begin
        rd_sel_reg <= ~rd_sel_reg;
      end
      if (wr_issue) begin
        wr_sel_reg <= ~wr_sel_reg;
        wr_buf_reg[wr_sel_reg] <= wr_data_in;
        wr_bsel_reg[wr_sel_reg] <= wr_byte_sel_n_in;
      end
      for (int i = 0; i < 2; i++) begin
        rd_slot_reg[i] <= rd_slot_next[i];
        wr_slot_reg[i] <= wr_slot_next[i];
      end
    end
  end

  always_comb begin
    rd_hit = 1'b0;
    rd_idx = 2'h0;
    wr_hit = 1'b0;
    wr_word = sram_pkg::DATA_RESET;
    wr_word_sel_n = sram_pkg::BYTE_SEL_IDLE;
    for (int i = 0; i < 2; i++) begin
      if (sram_pkg::in_window(rd_slot_next[i], sram_pkg::RD_FIRST_STEP, sram_pkg::RD_LAST_STEP)) begin
        rd_hit = 1'b1;
        rd_idx = sram_pkg::word_index(rd_slot_next[i].step, sram_pkg::RD_FIRST_STEP);
      end
      if (sram_pkg::in_window(wr_slot_next[i], sram_pkg::WR_FIRST_STEP, sram_pkg::WR_LAST_STEP)) begin
        wr_hit = 1'b1;
        wr_word = wr_buf_reg[i][sram_pkg::DATA_W *
                  sram_pkg::word_index(wr_slot_next[i].step, sram_pkg::WR_FIRST_STEP) +: sram_pkg::DATA_W];
        wr_word_sel_n = wr_bsel_reg[i][2 *
                        sram_pkg::word_index(wr_slot_next[i].step, sram_pkg::WR_FIRST_STEP) +: 2];
      end
    end
  end

  // Write words go out with the rise that the device takes them on.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      d_reg <= sram_pkg::DATA_RESET;
      bsel_n_reg <= sram_pkg::BYTE_SEL_IDLE;
    end else if (rise_now && wr_hit) begin
      d_reg <= wr_word;
      bsel_n_reg <= wr_word_sel_n;
    end
  end

  // The device answers one edge after it sees a rise, so read words are caught two edges after driving it.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cap1_reg <= 1'b0;
      cap2_reg <= 1'b0;
      cap1_idx_reg <= 2'h0;
      cap2_idx_reg <= 2'h0;
      rd_buf_reg <= sram_pkg::BURST_RESET;
      rd_data_out <= sram_pkg::BURST_RESET;
      rd_valid_out <= 1'b0;
    end else begin
      cap1_reg <= rise_now & rd_hit;
      cap1_idx_reg <= rd_idx;
      cap2_reg <= cap1_reg;
      cap2_idx_reg <= cap1_idx_reg;
      rd_valid_out <= cap2_reg && (cap2_idx_reg == sram_pkg::LAST_WORD);
      if (cap2_reg) begin
        rd_buf_reg[sram_pkg::DATA_W * cap2_idx_reg +: sram_pkg::DATA_W] <= link.q;
        if (cap2_idx_reg == sram_pkg::LAST_WORD) begin
          rd_data_out <= {link.q, rd_buf_reg[sram_pkg::BURST_W-sram_pkg::DATA_W-1:0]};
        end
      end
    end
  end

  assign link.k = k_reg;
  assign link.k_n = kn_reg;
  assign link.read_port_select_n = rd_port_n_reg;
  assign link.write_port_select_n = wr_port_n_reg;
  assign link.addr = addr_reg;
  assign link.d = d_reg;
  assign link.byte_write_select_n = bsel_n_reg;

endmodule : sram_controller

/* File: tb/sram_link_asserts.sv */
`timescale 1ns/1ps
module sram_link_asserts (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic k,
  input wire logic k_n,
  input wire logic read_port_select_n,
  input wire logic write_port_select_n,
  input wire logic [sram_pkg::DATA_W-1:0] q,
  input wire logic q_oe
);
  logic prev_k_reg;
  logic prev_kn_reg;
  logic rise_reg;
  logic last_rd_reg;
  logic last_wr_reg;
  logic [2:0] rd_rises_reg;
  logic pos_rise;
  logic neg_rise;
  logic rd_take;
  logic wr_take;
  logic stopped;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  // Both clocks high is the parked level, so a restart from it never forms a rise.
  assign pos_rise = k && !k_n && !prev_k_reg;
  assign neg_rise = k_n && !k && !prev_kn_reg;
  assign rd_take = pos_rise && !read_port_select_n && !last_rd_reg;
  assign wr_take = pos_rise && !write_port_select_n && !last_wr_reg && !rd_take;
  assign stopped = k && k_n;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      prev_k_reg <= 1'b1;
      prev_kn_reg <= 1'b1;
      rise_reg <= 1'b0;
    end else begin
      prev_k_reg <= k;
      prev_kn_reg <= k_n;
      rise_reg <= pos_rise || neg_rise;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      last_rd_reg <= 1'b0;
      last_wr_reg <= 1'b0;
    end else if (pos_rise) begin
      last_rd_reg <= rd_take;
      last_wr_reg <= wr_take;
    end
  end

  // Saturating count of positive rises since the last read start.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rd_rises_reg <= 3'h7;
    end else if (rd_take) begin
      rd_rises_reg <= 3'h0;
    end else if (pos_rise && rd_rises_reg != 3'h7) begin
      rd_rises_reg <= rd_rises_reg + 3'h1;
    end
  end

  power_up_idle_a: assert property ($rose(nrst_in) |-> !q_oe && stopped && read_port_select_n
    && write_port_select_n) else $error("link not idle after reset");
  no_low_park_a: assert property (k || k_n) else $error("both link clocks low");
  stop_freeze_a: assert property (stopped && $past(stopped) && $past(stopped, 2)
    |-> $stable(q) && $stable(q_oe)) else $error("read data moved while clocks stopped");
  rd_spacing_a: assert property (pos_rise && !read_port_select_n |-> !last_rd_reg)
    else $error("read started on consecutive positive rises");
  wr_spacing_a: assert property (pos_rise && !write_port_select_n |-> !last_wr_reg)
    else $error("write started on consecutive positive rises");
  rd_latency_a: assert property (rd_take ##1 (pos_rise || neg_rise) [*5] |=> q_oe)
    else $error("first read word late");
  idle_tristate_a: assert property (rd_rises_reg == 3'h7 |-> !q_oe)
    else $error("read data driven with no read pending");
  rise_launch_a: assert property ($changed(q) || $changed(q_oe) |-> rise_reg)
    else $error("read data changed without a clock rise");
endmodule : sram_link_asserts

/* File: tb/quad_rate_sram_burst_port_test.sv */
`timescale 1ns/1ps
module quad_rate_sram_burst_port_test;
  localparam logic [71:0] BURST0 = {18'h3C0F0, 18'h2A5A5, 18'h15A5A, 18'h0F0F3};
  localparam logic [71:0] BURST1 = {18'h01234, 18'h05678, 18'h09ABC, 18'h0DEF0};
  localparam logic [71:0] BURST2 = {18'h00AAA, 18'h3F555, 18'h12121, 18'h21212};
  localparam logic [71:0] LANE_NEW = {18'h13579, 18'h2468A, 18'h0ABCD, 18'h12345};
  localparam logic [71:0] LANE_EXP = {18'h3FFFF, 18'h247FF, 18'h3FFCD, 18'h12345};
  logic clk_in;
  logic nrst_in;
  logic clk_run_in;
  logic rd_req_in;
  logic [sram_pkg::ADDR_W-1:0] rd_addr_in;
  logic wr_req_in;
  logic [sram_pkg::ADDR_W-1:0] wr_addr_in;
  logic [sram_pkg::BURST_W-1:0] wr_data_in;
  logic [sram_pkg::SEL_BURST_W-1:0] wr_byte_sel_n_in;
  logic rd_ack_out;
  logic wr_ack_out;
  logic [sram_pkg::BURST_W-1:0] rd_data_out;
  logic rd_valid_out;
  logic wr_busy_a;
  logic rd_drop_b;
  logic wr_drop_b;
  int mismatches;
  int total_checks;

  sram_link_if la();
  sram_link_if lb();

  sram_controller i_sram_controller (.clk_in(clk_in), .nrst_in(nrst_in), .link(la), .clk_run_in(clk_run_in),
    .rd_req_in(rd_req_in), .rd_addr_in(rd_addr_in), .wr_req_in(wr_req_in), .wr_addr_in(wr_addr_in),
    .wr_data_in(wr_data_in), .wr_byte_sel_n_in(wr_byte_sel_n_in), .rd_ack_out(rd_ack_out),
    .wr_ack_out(wr_ack_out), .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out));
  sram_device i_sram_device (.clk_in(clk_in), .nrst_in(nrst_in), .link(la), .rd_busy_out(),
    .wr_busy_out(wr_busy_a), .rd_dropped_out(), .wr_dropped_out());
  // The second device faces the bench directly so that illegal start patterns can be sent.
  sram_device i_sram_device_b (.clk_in(clk_in), .nrst_in(nrst_in), .link(lb), .rd_busy_out(),
    .wr_busy_out(), .rd_dropped_out(rd_drop_b), .wr_dropped_out(wr_drop_b));
  sram_link_asserts chk (.clk_in(clk_in), .nrst_in(nrst_in), .k(la.k), .k_n(la.k_n),
    .read_port_select_n(la.read_port_select_n), .write_port_select_n(la.write_port_select_n),
    .q(la.q), .q_oe(la.q_oe));

  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  task automatic check_burst(input string what, input logic [71:0] exp, input logic [71:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check_burst

  task automatic check_bit(input string what, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask : check_bit

  task automatic do_write(input logic [19:0] addr, input logic [71:0] data, input logic [7:0] sel_n);
    int n;
    @(posedge clk_in);
    wr_addr_in <= addr;
    wr_data_in <= data;
    wr_byte_sel_n_in <= sel_n;
    wr_req_in <= 1'b1;
    for (n = 0; n < 20 && wr_ack_out !== 1'b1; n++) @(posedge clk_in);
    wr_req_in <= 1'b0;
    check_bit("write ack", 1'b1, wr_ack_out);
    // Busy lags the start by two edges, so looking earlier would see the idle level and return mid-burst.
    repeat (2) @(posedge clk_in);
    for (n = 0; n < 20; n++) begin
      @(posedge clk_in);
      if (wr_busy_a === 1'b0) break;
    end
    check_bit("write finished", 1'b0, wr_busy_a);
  endtask : do_write

  task automatic start_read(input logic [19:0] addr);
    int n;
    @(posedge clk_in);
    rd_addr_in <= addr;
    rd_req_in <= 1'b1;
    for (n = 0; n < 20 && rd_ack_out !== 1'b1; n++) @(posedge clk_in);
    rd_req_in <= 1'b0;
    check_bit("read ack", 1'b1, rd_ack_out);
  endtask : start_read

  // The wait is long enough to cover a clock stop in mid-burst.
  task automatic finish_read(input string what, input logic [71:0] exp);
    int n;
    // Always step one edge first: the valid pulse of the previous burst is still visible on entry.
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (n < 60 && rd_valid_out !== 1'b1);
    check_bit("read valid", 1'b1, rd_valid_out);
    check_burst(what, exp, rd_data_out);
  endtask : finish_read

  task automatic test_power_up;
    @(posedge clk_in);
    check_bit("link idle", 1'b1, la.k & la.k_n & la.read_port_select_n & la.write_port_select_n & ~la.q_oe);
    check_bit("far link tristated", 1'b0, lb.q_oe);
    clk_run_in <= 1'b1;
    $display("test power_up done");
  endtask : test_power_up

  task automatic test_bursts;
    do_write(20'h00104, BURST0, 8'h00);
    do_write(20'h00105, BURST1, 8'h00);
    start_read(20'h00104);
    start_read(20'h00105);
    finish_read("burst at A", BURST0);
    finish_read("burst at A+1", BURST1);
    $display("test bursts done");
  endtask : test_bursts

  task automatic test_byte_lanes;
    do_write(20'h00300, {4{18'h3FFFF}}, 8'h00);
    do_write(20'h00300, LANE_NEW, 8'hD8);
    start_read(20'h00300);
    finish_read("per-word lanes", LANE_EXP);
    $display("test byte_lanes done");
  endtask : test_byte_lanes

  task automatic test_both_requests;
    int n;
    int rd_t;
    int wr_t;
    rd_t = -1;
    wr_t = -1;
    @(posedge clk_in);
    rd_addr_in <= 20'h00104;
    wr_addr_in <= 20'h00200;
    wr_data_in <= BURST2;
    wr_byte_sel_n_in <= 8'h00;
    rd_req_in <= 1'b1;
    wr_req_in <= 1'b1;
    for (n = 0; n < 30 && (rd_t < 0 || wr_t < 0); n++) begin
      @(posedge clk_in);
      if (rd_ack_out === 1'b1) begin
        rd_t = n;
        rd_req_in <= 1'b0;
      end
      if (wr_ack_out === 1'b1) begin
        wr_t = n;
        wr_req_in <= 1'b0;
      end
    end
    check_bit("read issued first", 1'b1, rd_t >= 0 && rd_t < wr_t);
    finish_read("read beside write", BURST0);
    start_read(20'h00200);
    finish_read("write beside read", BURST2);
    $display("test both_requests done");
  endtask : test_both_requests

  task automatic test_clock_stop;
    logic [17:0] held;
    start_read(20'h00105);
    repeat (6) @(posedge clk_in);
    clk_run_in <= 1'b0;
    repeat (6) @(posedge clk_in);
    held = la.q;
    repeat (10) @(posedge clk_in);
    check_burst("q while stopped", {54'h0, held}, {54'h0, la.q});
    check_bit("clocks parked high", 1'b1, la.k & la.k_n);
    clk_run_in <= 1'b1;
    finish_read("read across stop", BURST1);
    $display("test clock_stop done");
  endtask : test_clock_stop

  // One positive rise with the given selects, then the clocks park high.
  task automatic pulse_b(input logic rd_port_n, input logic wr_port_n, input logic exp_rd, input logic exp_wr);
    logic rd_seen;
    logic wr_seen;
    rd_seen = 1'b0;
    wr_seen = 1'b0;
    @(posedge clk_in);
    lb.k <= 1'b0;
    @(posedge clk_in);
    lb.k <= 1'b1;
    lb.k_n <= 1'b0;
    lb.read_port_select_n <= rd_port_n;
    lb.write_port_select_n <= wr_port_n;
    @(posedge clk_in);
    lb.k_n <= 1'b1;
    lb.read_port_select_n <= 1'b1;
    lb.write_port_select_n <= 1'b1;
    repeat (4) begin
      @(posedge clk_in);
      rd_seen = rd_seen | (rd_drop_b === 1'b1);
      wr_seen = wr_seen | (wr_drop_b === 1'b1);
    end
    check_bit("read dropped", exp_rd, rd_seen);
    check_bit("write dropped", exp_wr, wr_seen);
  endtask : pulse_b

  task automatic test_refusals;
    pulse_b(1'b0, 1'b0, 1'b0, 1'b0);
    pulse_b(1'b0, 1'b0, 1'b1, 1'b0);
    pulse_b(1'b1, 1'b0, 1'b0, 1'b1);
    $display("test refusals done");
  endtask : test_refusals

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // The sequence needs well under a thousand cycles; four thousand leaves room for slow paths.
  initial begin
    repeat (4000) @(posedge clk_in);
    mismatches++;
    $display("watchdog expired");
    tally_and_finish();
  end

  initial begin
    mismatches = 0;
    total_checks = 0;
    nrst_in = 1'b0;
    clk_run_in = 1'b0;
    rd_req_in = 1'b0;
    rd_addr_in = 20'h00000;
    wr_req_in = 1'b0;
    wr_addr_in = 20'h00000;
    wr_data_in = 72'h000000000000000000;
    wr_byte_sel_n_in = 8'hFF;
    lb.k = 1'b1;
    lb.k_n = 1'b1;
    lb.read_port_select_n = 1'b1;
    lb.write_port_select_n = 1'b1;
    lb.addr = 20'h00000;
    lb.d = 18'h00000;
    lb.byte_write_select_n = 2'h3;
    repeat (4) @(posedge clk_in);
    nrst_in <= 1'b1;
    test_power_up();
    test_bursts();
    test_byte_lanes();
    test_both_requests();
    test_clock_stop();
    test_refusals();
    tally_and_finish();
  end
endmodule : quad_rate_sram_burst_port_test
